// File: hdl/lcdn_pkg.sv
// lcdn_pkg: shared constants for the lcd nibble-mode init link.
// assumes a single 100 MHz system clock on both ends.
package lcdn_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // least-time conversion: round up, never below one cycle
  function automatic int lcdn_min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // waits of the init sequence, in their own units
  localparam int POWER_WAIT_MS = 2;
  localparam int FIRST_GAP_MS = 2;
  localparam int SECOND_GAP_US = 40;
  localparam int EXEC_US = 40;
  localparam int POWER_WAIT_CYC = lcdn_min_cyc(POWER_WAIT_MS * 1000000);
  localparam int FIRST_GAP_CYC = lcdn_min_cyc(FIRST_GAP_MS * 1000000);
  localparam int SECOND_GAP_CYC = lcdn_min_cyc(SECOND_GAP_US * 1000);
  localparam int EXEC_CYC = lcdn_min_cyc(EXEC_US * 1000);

  // strobe timing of one bus access
  localparam int SETUP_NS = 60;
  localparam int STROBE_HIGH_NS = 450;
  localparam int STROBE_LOW_NS = 550;
  localparam int SETUP_CYC = lcdn_min_cyc(SETUP_NS);
  localparam int HIGH_CYC = lcdn_min_cyc(STROBE_HIGH_NS);
  localparam int LOW_CYC = lcdn_min_cyc(STROBE_LOW_NS);

  localparam int WAIT_W = 18;
  localparam int BUSY_W = 12;
  localparam int STEP_W = 4;

  // nibble patterns and instruction fields
  localparam logic [3:0] NIB_FSET_8 = 4'h3;
  localparam logic [3:0] NIB_FSET_4 = 4'h2;
  localparam logic [3:0] NIB_IDLE = 4'h0;
  localparam logic [3:0] NIB_PULLUP = 4'hf;
  localparam logic [2:0] FSET_TOP = 3'h1;
  localparam int WIDTH_BIT = 4;
  localparam int BUSY_BIT = 3;
  localparam logic [1:0] WIDTH_WRITES = 2'h3;
  localparam logic [7:0] INSTR_DISP_OFF = 8'h08;
  localparam logic [7:0] INSTR_CLEAR = 8'h01;
  localparam logic [5:0] ENTRY_TOP = 6'h01;

  // step layout of the host sequence
  localparam logic [STEP_W-1:0] STEP_LAST_8BIT = 4'h3;
  localparam logic [STEP_W-1:0] STEP_FIRST_4BIT = 4'h4;
  localparam logic [STEP_W-1:0] STEP_LAST_INIT = 4'h7;
  localparam logic [STEP_W-1:0] STEP_USER = 4'h8;

endpackage

// File: hdl/lcdn_if.sv
// lcdn_if: parallel host port wires between host and lcd device.
// the shared upper nibble is resolved here from the two enables;
// undriven lines read high as if pulled up.
`timescale 1ns/1ps
`default_nettype none
interface lcdn_if;
  import lcdn_pkg::*;

  logic instr_data_select;
  logic read_write_select;
  logic strobe;
  logic [3:0] host_upper;
  logic host_upper_oe;
  logic [3:0] host_lower;
  logic host_lower_oe;
  logic [3:0] dev_upper;
  logic dev_upper_oe;
  logic [3:0] upper_level;
  logic [3:0] lower_level;

  // wire level: host wins a clash, else device, else pull-up
  assign upper_level = host_upper_oe ? host_upper :
                       (dev_upper_oe ? dev_upper : NIB_PULLUP);
  assign lower_level = host_lower_oe ? host_lower : NIB_PULLUP;

  modport host (
    output instr_data_select, read_write_select, strobe,
    output host_upper, host_upper_oe, host_lower, host_lower_oe,
    input upper_level
  );

  modport device (
    input instr_data_select, read_write_select, strobe,
    input upper_level, lower_level,
    output dev_upper, dev_upper_oe
  );
endinterface
`default_nettype wire

// File: hdl/lcdn_device.sv
// lcdn_device: lcd controller end of the parallel port, 8/4-bit width.
// assumes bus inputs synchronous to sys_clk_in; latches on strobe fall.
`timescale 1ns/1ps
`default_nettype none
module lcdn_device
  import lcdn_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  lcdn_if.device bus,
  input wire logic serial_bus_sel_in,
  output logic instr_valid_out,
  output logic instr_is_data_out,
  output logic [7:0] instr_byte_out,
  output logic four_bit_mode_out,
  output logic busy_valid_out,
  output logic busy_out
);

  logic strobe_prev_q, strobe_prev_d;
  logic four_bit_q, four_bit_d;
  logic phase_q, phase_d;
  logic [3:0] hi_nib_q, hi_nib_d;
  logic [1:0] width_cnt_q, width_cnt_d;
  logic busy_q, busy_d;
  logic [BUSY_W-1:0] busy_cnt_q, busy_cnt_d;
  logic oe_q, oe_d;
  logic [3:0] dout_q, dout_d;
  logic valid_q, valid_d;
  logic is_data_q, is_data_d;
  logic [7:0] byte_q, byte_d;
  logic busy_valid_q, busy_valid_d;

  // next state: sample on strobe fall, run busy timer, drive reads
  always_comb begin
    logic fall;
    logic exec;
    logic [7:0] word;
    fall = 1'b0;
    exec = 1'b0;
    word = 8'h00;
    strobe_prev_d = bus.strobe;
    four_bit_d = four_bit_q;
    phase_d = phase_q;
    hi_nib_d = hi_nib_q;
    width_cnt_d = width_cnt_q;
    busy_d = busy_q;
    busy_cnt_d = busy_cnt_q;
    valid_d = 1'b0;
    is_data_d = is_data_q;
    byte_d = byte_q;
    // serial operation leaves the parallel port dead [RULE7]
    fall = strobe_prev_q && !bus.strobe && !serial_bus_sel_in;
    if (busy_q) begin
      if (busy_cnt_q == '0) begin
        busy_d = 1'b0;
      end else begin
        busy_cnt_d = busy_cnt_q - 1'b1;
      end
    end
    if (fall && bus.read_write_select && four_bit_q) begin
      phase_d = !phase_q; // reads also come as nibble pairs [RULE5]
    end
    if (fall && !bus.read_write_select) begin
      if (!four_bit_q) begin
        word = {bus.upper_level, bus.lower_level};
        exec = 1'b1;
      end else if (!phase_q) begin
        hi_nib_d = bus.upper_level; // high nibble first [RULE5]
        phase_d = 1'b1;
      end else begin
        // lower lines ignored; whole byte only now [RULE8]
        word = {hi_nib_q, bus.upper_level};
        phase_d = 1'b0;
        exec = 1'b1;
      end
    end
    if (exec) begin
      valid_d = 1'b1;
      is_data_d = bus.instr_data_select;
      byte_d = word;
      busy_d = 1'b1;
      busy_cnt_d = BUSY_W'(EXEC_CYC - 1);
      if (!bus.instr_data_select && word[7:5] == FSET_TOP) begin
        // width bit low selects nibble mode [RULE4]
        four_bit_d = !word[WIDTH_BIT];
        if (!four_bit_q && word[WIDTH_BIT] &&
            width_cnt_q != WIDTH_WRITES) begin
          width_cnt_d = width_cnt_q + 1'b1; // [RULE3]
        end
      end
    end
    // busy reads as set until the third width write [RULE3]
    oe_d = bus.strobe && bus.read_write_select &&
           !bus.instr_data_select && !serial_bus_sel_in;
    if (four_bit_q && phase_q) begin
      dout_d = NIB_IDLE;
    end else begin
      dout_d = {busy_q || (width_cnt_q != WIDTH_WRITES), 3'h0};
    end
    // registered so the output comes straight from a flop
    busy_valid_d = (width_cnt_d == WIDTH_WRITES);
  end

  // registers; device powers up as if in the unknown 8-bit state
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_prev_q <= 1'b0;
      four_bit_q <= 1'b0;
      phase_q <= 1'b0;
      hi_nib_q <= 4'h0;
      width_cnt_q <= 2'h0;
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
      oe_q <= 1'b0;
      dout_q <= 4'h0;
      valid_q <= 1'b0;
      is_data_q <= 1'b0;
      byte_q <= 8'h00;
      busy_valid_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_prev_d;
      four_bit_q <= four_bit_d;
      phase_q <= phase_d;
      hi_nib_q <= hi_nib_d;
      width_cnt_q <= width_cnt_d;
      busy_q <= busy_d;
      busy_cnt_q <= busy_cnt_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
      valid_q <= valid_d;
      is_data_q <= is_data_d;
      byte_q <= byte_d;
      busy_valid_q <= busy_valid_d;
    end
  end

  assign bus.dev_upper = dout_q;
  assign bus.dev_upper_oe = oe_q;
  assign instr_valid_out = valid_q;
  assign instr_is_data_out = is_data_q;
  assign instr_byte_out = byte_q;
  assign four_bit_mode_out = four_bit_q;
  assign busy_valid_out = busy_valid_q;
  assign busy_out = busy_q;

endmodule
`default_nettype wire

// File: hdl/lcdn_host.sv
// lcdn_host: microcontroller end that runs the 4-bit init sequence,
// then forwards user instructions as nibble pairs.
// assumes the device shares sys_clk_in and starts from power-on.
//
// Function
// RULE1 - wait 2 ms after power before writing
// RULE2 - three 0011 writes, 2 ms then 40 us
// RULE3 - busy pollable after third; else wait execution
// RULE4 - single 0010 write switches to 4-bit
// RULE5 - nibble pairs, high first; function set 0010/NM00
// RULE6 - display off, clear, entry mode as pairs
// RULE7 - parallel port only, never over serial bus
// RULE8 - device assembles byte after second nibble only
`timescale 1ns/1ps
`default_nettype none
module lcdn_host
  import lcdn_pkg::*;
#(
  parameter int POWER_WAIT_CYCLES = POWER_WAIT_CYC,
  parameter int FIRST_GAP_CYCLES = FIRST_GAP_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  lcdn_if.host bus,
  input wire logic serial_bus_sel_in,
  input wire logic poll_busy_in,
  input wire logic line_count_in,
  input wire logic voltage_char_in,
  input wire logic increment_in,
  input wire logic shift_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_is_data_in,
  input wire logic [7:0] cmd_byte_in,
  output logic cmd_ready_out,
  output logic init_done_out,
  output logic refused_out
);

  typedef enum logic [3:0] {
    ST_POWER, ST_WSETUP, ST_WHIGH, ST_WLOW, ST_GAP,
    ST_PSETUP, ST_PHIGH, ST_PLOW, ST_READY, ST_REFUSED
  } lcdn_state_type;

  // setup instruction bytes sent after the width switch
  function automatic logic [7:0] lcdn_init_byte(
    input logic [1:0] idx, input logic n, input logic m,
    input logic id, input logic s);
    case (idx)
      2'h0: lcdn_init_byte = {NIB_FSET_4, n, m, 2'h0}; // [RULE5]
      2'h1: lcdn_init_byte = INSTR_DISP_OFF; // [RULE6]
      2'h2: lcdn_init_byte = INSTR_CLEAR; // [RULE6]
      default: lcdn_init_byte = {ENTRY_TOP, id, s}; // [RULE6]
    endcase
  endfunction

  lcdn_state_type state_q, state_d;
  logic [STEP_W-1:0] step_q, step_d;
  logic [WAIT_W-1:0] cnt_q, cnt_d;
  logic second_q, second_d;
  logic [7:0] byte_q, byte_d;
  logic rs_sel_q, rs_sel_d;
  logic busy_smp_q, busy_smp_d;
  logic rs_q, rs_d;
  logic rw_q, rw_d;
  logic strobe_q, strobe_d;
  logic [3:0] up_q, up_d;
  logic up_oe_q, up_oe_d;
  logic lo_oe_q, lo_oe_d;
  logic ready_q, ready_d;
  logic done_q, done_d;
  logic refused_q, refused_d;

  // sequencer: one bus access at a time, waits counted down in cnt
  always_comb begin
    logic advance;
    logic four_bit;
    logic [STEP_W-1:0] nxt;
    advance = 1'b0;
    four_bit = (step_q >= STEP_LAST_8BIT);
    nxt = step_q + 1'b1;
    state_d = state_q;
    step_d = step_q;
    cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
    second_d = second_q;
    byte_d = byte_q;
    rs_sel_d = rs_sel_q;
    busy_smp_d = busy_smp_q;
    rs_d = rs_q;
    rw_d = rw_q;
    strobe_d = 1'b0;
    up_d = up_q;
    up_oe_d = up_oe_q;
    lo_oe_d = lo_oe_q;
    ready_d = ready_q;
    done_d = done_q;
    refused_d = refused_q;
    case (state_q)
      ST_POWER: begin
        if (cnt_q == '0) begin // [RULE1]
          if (serial_bus_sel_in) begin
            state_d = ST_REFUSED; // [RULE7]
            refused_d = 1'b1;
          end else begin
            state_d = ST_WSETUP;
            cnt_d = WAIT_W'(SETUP_CYC - 1);
          end
        end
      end
      ST_WSETUP: begin
        rs_d = (step_q < STEP_FIRST_4BIT) ? 1'b0 : rs_sel_q;
        rw_d = 1'b0;
        up_oe_d = 1'b1;
        lo_oe_d = (step_q < STEP_FIRST_4BIT); // [RULE8]
        if (step_q < STEP_LAST_8BIT) begin
          up_d = NIB_FSET_8; // [RULE2]
        end else if (step_q == STEP_LAST_8BIT) begin
          up_d = NIB_FSET_4; // [RULE4]
        end else begin
          up_d = second_q ? byte_q[3:0] : byte_q[7:4]; // [RULE5]
        end
        if (cnt_q == '0) begin
          state_d = ST_WHIGH;
          strobe_d = 1'b1;
          cnt_d = WAIT_W'(HIGH_CYC - 1);
        end
      end
      ST_WHIGH: begin
        strobe_d = (cnt_q != '0);
        if (cnt_q == '0) begin
          state_d = ST_WLOW;
          cnt_d = WAIT_W'(LOW_CYC - 1);
        end
      end
      ST_WLOW: begin
        if (cnt_q == '0) begin
          up_oe_d = 1'b0;
          lo_oe_d = 1'b0;
          if (step_q >= STEP_FIRST_4BIT && !second_q) begin
            second_d = 1'b1; // low nibble follows at once [RULE5]
            state_d = ST_WSETUP;
            cnt_d = WAIT_W'(SETUP_CYC - 1);
          end else if (step_q == 4'h0) begin
            state_d = ST_GAP; // no polling yet [RULE2]
            cnt_d = WAIT_W'(FIRST_GAP_CYCLES - 1);
          end else if (step_q == 4'h1) begin
            state_d = ST_GAP; // [RULE2]
            cnt_d = WAIT_W'(SECOND_GAP_CYC - 1);
          end else if (poll_busy_in) begin
            second_d = 1'b0;
            state_d = ST_PSETUP; // [RULE3]
            cnt_d = WAIT_W'(SETUP_CYC - 1);
          end else begin
            second_d = 1'b0;
            state_d = ST_GAP; // [RULE3]
            cnt_d = WAIT_W'(EXEC_CYC - 1);
          end
        end
      end
      ST_GAP: begin
        advance = (cnt_q == '0);
      end
      ST_PSETUP: begin
        rs_d = 1'b0;
        rw_d = 1'b1;
        up_oe_d = 1'b0;
        if (cnt_q == '0) begin
          state_d = ST_PHIGH;
          strobe_d = 1'b1;
          cnt_d = WAIT_W'(HIGH_CYC - 1);
        end
      end
      ST_PHIGH: begin
        strobe_d = (cnt_q != '0);
        if (cnt_q == '0) begin
          if (!second_q) begin
            busy_smp_d = bus.upper_level[BUSY_BIT]; // [RULE3]
          end
          state_d = ST_PLOW;
          cnt_d = WAIT_W'(LOW_CYC - 1);
        end
      end
      ST_PLOW: begin
        if (cnt_q == '0) begin
          rw_d = 1'b0;
          cnt_d = WAIT_W'(SETUP_CYC - 1);
          if (four_bit && !second_q) begin
            second_d = 1'b1; // second read nibble [RULE5]
            state_d = ST_PSETUP;
          end else begin
            second_d = 1'b0;
            if (busy_smp_q) begin
              state_d = ST_PSETUP;
            end else begin
              advance = 1'b1;
            end
          end
        end
      end
      ST_READY: begin
        if (cmd_valid_in) begin
          byte_d = cmd_byte_in;
          rs_sel_d = cmd_is_data_in;
          second_d = 1'b0;
          ready_d = 1'b0;
          state_d = ST_WSETUP;
          cnt_d = WAIT_W'(SETUP_CYC - 1);
        end
      end
      ST_REFUSED: begin
        refused_d = 1'b1;
      end
      default: begin
        state_d = ST_POWER;
      end
    endcase
    // step to the next access once the wait or poll is over
    if (advance) begin
      second_d = 1'b0;
      if (step_q >= STEP_LAST_INIT) begin
        step_d = STEP_USER;
        state_d = ST_READY;
        ready_d = 1'b1;
        done_d = 1'b1;
      end else begin
        step_d = nxt;
        state_d = ST_WSETUP;
        cnt_d = WAIT_W'(SETUP_CYC - 1);
        if (nxt >= STEP_FIRST_4BIT) begin
          rs_sel_d = 1'b0;
          byte_d = lcdn_init_byte(nxt[1:0], line_count_in,
                                  voltage_char_in, increment_in, shift_in);
        end
      end
    end
  end

  // registers; the power-on wait starts loaded at reset
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_POWER;
      step_q <= '0;
      cnt_q <= WAIT_W'(POWER_WAIT_CYCLES - 1);
      second_q <= 1'b0;
      byte_q <= 8'h00;
      rs_sel_q <= 1'b0;
      busy_smp_q <= 1'b0;
      rs_q <= 1'b0;
      rw_q <= 1'b0;
      strobe_q <= 1'b0;
      up_q <= 4'h0;
      up_oe_q <= 1'b0;
      lo_oe_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      second_q <= second_d;
      byte_q <= byte_d;
      rs_sel_q <= rs_sel_d;
      busy_smp_q <= busy_smp_d;
      rs_q <= rs_d;
      rw_q <= rw_d;
      strobe_q <= strobe_d;
      up_q <= up_d;
      up_oe_q <= up_oe_d;
      lo_oe_q <= lo_oe_d;
      ready_q <= ready_d;
      done_q <= done_d;
      refused_q <= refused_d;
    end
  end

  // pins straight from flops; lower lines are don't-care zeros
  assign bus.instr_data_select = rs_q;
  assign bus.read_write_select = rw_q;
  assign bus.strobe = strobe_q;
  assign bus.host_upper = up_q;
  assign bus.host_upper_oe = up_oe_q;
  assign bus.host_lower = NIB_IDLE;
  assign bus.host_lower_oe = lo_oe_q;
  assign cmd_ready_out = ready_q;
  assign init_done_out = done_q;
  assign refused_out = refused_q;

endmodule
`default_nettype wire

// File: testbench/lcdn_properties.sv
// lcdn_properties: order and timing checks on the host-device port.
// assumes one 100 MHz clock and an async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lcdn_properties
  import lcdn_pkg::*;
#(
  parameter int POWER_WAIT_CYCLES = 50,
  parameter int FIRST_GAP_CYCLES = 50
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic instr_data_select,
  input wire logic read_write_select,
  input wire logic strobe,
  input wire logic [3:0] host_upper,
  input wire logic host_lower_oe,
  input wire logic dev_upper_oe
);
  logic strobe_q, strobe_d;
  logic [7:0] wcnt_q, wcnt_d;
  logic [7:0] hi_q, hi_d;
  logic [19:0] gap_q, gap_d;

  // write count, strobe-high length, low gap; gap saturates, no wrap
  always_comb begin
    strobe_d = strobe;
    wcnt_d = wcnt_q;
    if (strobe_q && !strobe && !read_write_select && wcnt_q != 8'hff) begin
      wcnt_d = wcnt_q + 8'h01;
    end
    hi_d = strobe ? hi_q + 8'h01 : 8'h00;
    gap_d = strobe ? 20'h00000 : gap_q + {19'h00000, gap_q != 20'hfffff};
  end

  // helper registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_q <= 1'b0;
      wcnt_q <= 8'h00;
      hi_q <= 8'h00;
      gap_q <= 20'h00000;
    end else begin
      strobe_q <= strobe_d;
      wcnt_q <= wcnt_d;
      hi_q <= hi_d;
      gap_q <= gap_d;
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_power_wait: assert property ($rose(strobe) && wcnt_q == 8'h00 |->
    gap_q >= POWER_WAIT_CYCLES) else $error("first write too early");
  a_width_writes: assert property ($rose(strobe) && !read_write_select &&
    wcnt_q < 8'h03 |-> host_upper == NIB_FSET_8 && !instr_data_select)
    else $error("width write pattern wrong");
  a_first_gap: assert property ($rose(strobe) && wcnt_q == 8'h01 |->
    gap_q >= FIRST_GAP_CYCLES) else $error("first gap too short");
  a_second_gap: assert property ($rose(strobe) && wcnt_q == 8'h02 |->
    gap_q >= SECOND_GAP_CYC) else $error("second gap too short");
  a_poll_late: assert property ($rose(strobe) && read_write_select |->
    wcnt_q >= 8'h03) else $error("busy polled too early");
  a_dev_answers: assert property ($rose(strobe) && read_write_select |->
    ##[1:3] dev_upper_oe) else $error("device did not answer read");
  a_switch_write: assert property ($rose(strobe) && !read_write_select &&
    wcnt_q == 8'h03 |-> host_upper == NIB_FSET_4) else $error("no switch");
  a_strobe_len: assert property ($fell(strobe) |->
    hi_q == 8'(HIGH_CYC)) else $error("strobe high length wrong");
  a_hold_stable: assert property (strobe && $past(strobe) |->
    $stable(host_upper) && $stable(instr_data_select)) else $error("moved");
  a_pair_follow: assert property ($fell(strobe) && !read_write_select &&
    wcnt_q >= 8'h04 && !wcnt_q[0] |-> ##[1:80] $rose(strobe))
    else $error("second nibble late");
  a_upper_only: assert property (strobe && wcnt_q >= 8'h04 |->
    !host_lower_oe) else $error("lower lines driven in nibble mode");

  c_poll: cover property ($rose(strobe) && read_write_select);
  c_data: cover property ($fell(strobe) && instr_data_select);
  c_init_end: cover property ($rose(strobe) && wcnt_q == 8'h0b);
endmodule
`default_nettype wire

// File: testbench/tb.sv
// tb: joins host and device through the port and checks init runs.
// assumes design files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lcdn_pkg::*;
  localparam int PW = 50;
  localparam int LIMIT = 90000;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ser = 1'b0;
  logic poll = 1'b0;
  logic [3:0] fld = 4'h0;
  logic cmd_valid = 1'b0;
  logic cmd_is_data = 1'b0;
  logic [7:0] cmd_byte = 8'h00;
  logic cmd_ready, init_done, refused, ivalid, is_data, four, bvalid, busy;
  logic [7:0] ibyte;
  logic [8:0] got_q[$];
  logic [8:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int strobes = 0;
  int reads = 0;

  lcdn_if i_lcdn_if();
  lcdn_host #(.POWER_WAIT_CYCLES(PW), .FIRST_GAP_CYCLES(PW)) i_lcdn_host (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(i_lcdn_if),
    .serial_bus_sel_in(ser), .poll_busy_in(poll), .line_count_in(fld[3]),
    .voltage_char_in(fld[2]), .increment_in(fld[1]), .shift_in(fld[0]),
    .cmd_valid_in(cmd_valid), .cmd_is_data_in(cmd_is_data),
    .cmd_byte_in(cmd_byte), .cmd_ready_out(cmd_ready),
    .init_done_out(init_done), .refused_out(refused));
  lcdn_device i_lcdn_device (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(i_lcdn_if),
    .serial_bus_sel_in(ser), .instr_valid_out(ivalid),
    .instr_is_data_out(is_data), .instr_byte_out(ibyte),
    .four_bit_mode_out(four), .busy_valid_out(bvalid), .busy_out(busy));
  lcdn_properties #(.POWER_WAIT_CYCLES(PW), .FIRST_GAP_CYCLES(PW))
    i_lcdn_properties (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .instr_data_select(i_lcdn_if.instr_data_select),
    .read_write_select(i_lcdn_if.read_write_select),
    .strobe(i_lcdn_if.strobe), .host_upper(i_lcdn_if.host_upper),
    .host_lower_oe(i_lcdn_if.host_lower_oe),
    .dev_upper_oe(i_lcdn_if.dev_upper_oe));

  always #5 sys_clk_in = ~sys_clk_in;

  // collect finished bytes, count accesses, cut a hang short
  always @(posedge sys_clk_in) begin
    cyc++;
    if (ivalid === 1'b1) got_q.push_back({is_data, ibyte});
    if ($rose(i_lcdn_if.strobe)) begin
      strobes++;
      reads += int'(i_lcdn_if.read_write_select);
    end
    if (cyc >= LIMIT) begin
      err_total++;
      results();
    end
  end

  // byte i of the init run as the device should assemble it
  function automatic logic [8:0] init_exp(input int i, input logic [3:0] f);
    case (i)
      0, 1, 2: return 9'h030;
      3: return 9'h020;
      4: return {1'b0, 4'h2, f[3], f[2], 2'b00};
      5: return 9'h008;
      6: return 9'h001;
      default: return {1'b0, 6'h01, f[1:0]};
    endcase
  endfunction

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_all();
    chk(9'(got_q.size()), 9'(exp_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i], exp_q[i]);
  endtask

  // reset held 6 cycles; fields drawn while the host is held
  task automatic start_run(input logic s, input logic p);
    @(posedge sys_clk_in);
    #1;
    rst_in = 1'b1;
    ser = s;
    poll = p;
    fld = 4'($urandom);
    got_q.delete();
    exp_q.delete();
    strobes = 0;
    reads = 0;
    repeat (6) @(posedge sys_clk_in);
    #1;
    rst_in = 1'b0;
  endtask

  task automatic wait_init();
    for (int k = 0; k < 40000 && init_done !== 1'b1; k++) begin
      @(posedge sys_clk_in);
    end
    repeat (10) @(posedge sys_clk_in);
    for (int i = 0; i < 8; i++) exp_q.push_back(init_exp(i, fld));
    check_all();
    chk({8'h00, four}, 9'h001);
    chk({8'h00, bvalid}, 9'h001);
    chk({8'h00, busy}, 9'h000);
    chk({8'h00, init_done}, 9'h001);
  endtask

  // request held until an edge with ready high takes it
  task automatic send_cmd(input logic d, input logic [7:0] b);
    // a wide function set would drop the device out of nibble mode
    if (!d && b[7:5] == FSET_TOP) b[4] = 1'b0;
    @(posedge sys_clk_in);
    #1;
    cmd_valid = 1'b1;
    cmd_is_data = d;
    cmd_byte = b;
    for (int k = 0; k < 20000 && cmd_ready !== 1'b1; k++) begin
      @(posedge sys_clk_in);
      #1;
    end
    @(posedge sys_clk_in);
    #1;
    cmd_valid = 1'b0;
    exp_q.push_back({d, b});
    for (int k = 0; k < 20000 && got_q.size() < exp_q.size(); k++) begin
      @(posedge sys_clk_in);
    end
  endtask

  initial begin
    void'($urandom(32'hedfca688));
    start_run(1'b0, 1'b0);
    wait_init();
    send_cmd(1'b1, 8'hff);
    repeat (2) send_cmd(1'($urandom), 8'($urandom));
    check_all();
    $display("test timed_init done");
    start_run(1'b0, 1'b1);
    wait_init();
    chk({8'h00, 1'(reads > 0)}, 9'h001);
    send_cmd(1'b0, 8'($urandom));
    check_all();
    $display("test polled_init done");
    start_run(1'b1, 1'b0);
    repeat (PW + 400) @(posedge sys_clk_in);
    chk({8'h00, refused}, 9'h001);
    chk(9'(strobes), 9'h000);
    chk({8'h00, init_done}, 9'h000);
    $display("test serial_refuse done");
    results();
  end
endmodule
`default_nettype wire
